// [dv/crt_pin_model.sv]
// far side of the timer: count input, trigger input and timer 1 overflow
// assumes pins idle high through pull-ups and the bench asks on sys_clk edges
`default_nettype none
module crt_pin_model (
  // clock
  input wire logic sys_clk,
  // requests from the bench
  input wire logic cntReq,
  input wire logic trigLow,
  input wire logic t1Req,
  // pins
  output logic countPin,
  output logic trigPin,
  output logic timer1Ovf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lowCnt_q = 2'h0;
  // a count request gives one low pulse of three cycles, long enough to be seen once
  always @(posedge sys_clk)
  begin
    if (cntReq && lowCnt_q == 2'h0)
      lowCnt_q <= 2'h3;
    else if (lowCnt_q != 2'h0)
      lowCnt_q <= lowCnt_q - 2'h1;
  end
  // count and trigger pins idle high between requests; timer 1 overflow idles low
  assign countPin = (lowCnt_q == 2'h0);
  assign trigPin = !trigLow;
  assign timer1Ovf = t1Req;
endmodule
`default_nettype wire

// [dv/crt_timer_test.sv]
// self-checking bench for the capture/reload timer: bus tasks, pin model, random values
// assumes one bus master, word accesses and pins idling high
`default_nettype none
module crt_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RCtl = crt_pkg::IdxCtrl;
  localparam logic [7:0] RMod = crt_pkg::IdxMode;
  localparam logic [7:0] RCL = crt_pkg::IdxCapLo;
  localparam logic [7:0] RCH = crt_pkg::IdxCapHi;
  localparam logic [7:0] RNL = crt_pkg::IdxCntLo;
  localparam logic [7:0] RNH = crt_pkg::IdxCntHi;
  logic sys_clk, rst, hready, hreadyout, hresp, hwrite, irqReq, rxBaudTick, txBaudTick;
  logic countPin, trigPin, timer1Ovf, cntReq, trigLow, t1Req;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] rd, lo, hi;
  logic [7:0] gap = 8'h00;
  logic [7:0] lastTx = 8'h00;
  logic [7:0] cyc = 8'h00;
  logic [7:0] rxCnt = 8'h00;
  int errors = 0;
  int tests_run = 0;
  int seed = 32'hd58a;
  assign hready = hreadyout;
  crt_timer i_dut (.sys_clk(sys_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(crt_pkg::SizeWord), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .countPin(countPin), .trigPin(trigPin), .timer1Ovf(timer1Ovf),
    .irqReq(irqReq), .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick));
  crt_pin_model i_pins (.sys_clk(sys_clk), .cntReq(cntReq), .trigLow(trigLow), .t1Req(t1Req),
    .countPin(countPin), .trigPin(trigPin), .timer1Ovf(timer1Ovf));
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // serial tick bookkeeping: receive count and transmit spacing
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 8'h01;
    if (rxBaudTick === 1'b1)
      rxCnt <= rxCnt + 8'h01;
    if (txBaudTick === 1'b1)
    begin
      gap <= cyc - lastTx;
      lastTx <= cyc;
    end
  end
  // expected control byte, msb first
  function automatic logic [7:0] ctl(input logic o, e, rs, ts, en, r, s, c);
    return {o, e, rs, ts, en, r, s, c};
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    tests_run++;
    if (got !== e)
    begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, e);
    end
  endtask
  // one single word transfer; holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    htrans <= crt_pkg::TransNonseq;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    @(posedge sys_clk);
    while (hready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (hready !== 1'b1)
      errors++;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge sys_clk);
    while (hready !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (hready !== 1'b1)
      errors++;
    rd = hrdata[7:0];
    chk({7'h0, hresp}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rd, e);
  endtask
  task automatic endTest(input string s);
    $display("test %s done, %0d mismatches so far", s, errors);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cntReq = 1'b0;
    trigLow = 1'b0;
    t1Req = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // reset values, random storage, unmapped place
    rc(RCtl, crt_pkg::CtrlReset);
    rc(RMod, crt_pkg::ModeReset);
    repeat (4)
    begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      wr(RCL, lo);
      wr(RCH, hi);
      wr(RMod, lo);
      rc(RCL, lo);
      rc(RCH, hi);
      rc(RMod, lo & crt_pkg::ModeMask);
    end
    wr(8'h00, 8'h5A);
    rc(8'h00, 8'h00);
    endTest("registers");
    // up count wraps to the reload value, then stop holds the count
    wr(RMod, 8'h00);
    wr(crt_pkg::IdxClkCtl, 8'h20);
    lo = 8'($random(seed)) & 8'h7F;
    hi = 8'($random(seed)) & 8'h7F;
    wr(RCL, lo);
    wr(RCH, hi);
    wr(RNL, 8'hFE);
    wr(RNH, 8'hFF);
    wr(RCtl, ctl(0, 0, 0, 0, 0, 1, 0, 0));
    w(12);
    rc(RCtl, ctl(1, 0, 0, 0, 0, 1, 0, 0));
    chk({7'h0, irqReq}, 8'h01);
    wr(RCtl, 8'h00);
    rc(RCtl, 8'h00);
    rc(RNH, hi);
    bus(1'b0, RNL, 8'h00);
    chk({7'h0, (rd - lo) < 8'd8}, 8'h01);
    w(20);
    rc(RNL, rd);
    chk({7'h0, irqReq}, 8'h00);
    endTest("reload");
    // capture: ignored while disabled, then copies and auto-clears
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    wr(RCL, 8'h00);
    wr(RCH, 8'h00);
    wr(RNL, lo);
    wr(RNH, hi);
    wr(RCtl, ctl(0, 0, 0, 0, 0, 1, 1, 1));
    trigLow <= 1'b1;
    w(8);
    rc(RCL, 8'h00);
    rc(RCtl, ctl(0, 0, 0, 0, 0, 1, 1, 1));
    trigLow <= 1'b0;
    w(4);
    wr(RCtl, ctl(0, 0, 0, 0, 1, 1, 1, 1));
    trigLow <= 1'b1;
    w(8);
    rc(RCL, lo);
    rc(RCH, hi);
    rc(RCtl, ctl(0, 1, 0, 0, 1, 1, 1, 1));
    chk({7'h0, irqReq}, 8'h01);
    wr(RMod, 8'h08);
    trigLow <= 1'b0;
    w(4);
    trigLow <= 1'b1;
    w(8);
    rc(RNL, 8'h00);
    rc(RNH, 8'h00);
    rc(RCtl, ctl(0, 1, 0, 0, 1, 1, 1, 1));
    endTest("capture");
    // counter mode counts falling edges of the count pin
    trigLow <= 1'b0;
    wr(RMod, 8'h00);
    wr(RCtl, ctl(0, 0, 0, 0, 0, 1, 1, 0));
    wr(RNL, 8'h00);
    wr(RNH, 8'h00);
    lo = (8'($random(seed)) & 8'h07) + 8'h01;
    repeat (lo)
    begin
      cntReq <= 1'b1;
      @(posedge sys_clk);
      cntReq <= 1'b0;
      w(7);
    end
    w(6);
    rc(RNL, lo);
    endTest("counter");
    // down count with trigger low: match reloads all ones
    wr(RCtl, 8'h00);
    wr(RMod, 8'h01);
    wr(RCL, 8'h10);
    wr(RCH, 8'h00);
    wr(RNL, 8'h12);
    wr(RNH, 8'h00);
    trigLow <= 1'b1;
    wr(RCtl, ctl(0, 0, 0, 0, 0, 1, 0, 0));
    w(16);
    rc(RNH, 8'hFF);
    rc(RCtl, ctl(1, 1, 0, 0, 0, 1, 0, 0));
    endTest("down");
    // baud mode: fixed step, reload on overflow, no overflow flag
    trigLow <= 1'b0;
    wr(RMod, 8'h00);
    wr(RCL, 8'hF0);
    wr(RCH, 8'hFF);
    wr(RNL, 8'hF0);
    wr(RNH, 8'hFF);
    wr(RCtl, ctl(0, 0, 0, 1, 0, 1, 0, 1));
    w(80);
    chk(gap, 8'd32);
    rc(RCtl, ctl(0, 0, 0, 1, 0, 1, 0, 1));
    lo = rxCnt;
    repeat (3)
    begin
      t1Req <= 1'b1;
      @(posedge sys_clk);
      t1Req <= 1'b0;
      w(3);
    end
    w(2);
    chk(rxCnt - lo, 8'h03);
    endTest("baud");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [rtl/crt_fall_detect.sv]
// pin synchroniser with falling edge detection
// assumes the pin idles high
`default_nettype none
module crt_fall_detect (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin side
  input wire logic pinIn,
  // core side
  output logic level,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // two-stage synchroniser then one history stage
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one pulse per high-to-low step of the synced level
  assign level = sync_q;
  assign fall = prev_q & ~sync_q;
endmodule
`default_nettype wire

// [rtl/crt_pkg.sv]
// constants and carriers shared by the capture/reload timer files
// assumes a 100 MHz core clock and word-aligned AHB-Lite register access
`default_nettype none
package crt_pkg;
  // core clock
  localparam int unsigned ClkHz = 100_000_000;
  // register indices; byte address is four times the index
  localparam logic [7:0] IdxCtrl = 8'hC8;
  localparam logic [7:0] IdxMode = 8'hC9;
  localparam logic [7:0] IdxCapLo = 8'hCA;
  localparam logic [7:0] IdxCapHi = 8'hCB;
  localparam logic [7:0] IdxCntLo = 8'hCC;
  localparam logic [7:0] IdxCntHi = 8'hCD;
  localparam logic [7:0] IdxClkCtl = 8'h8E;
  // field positions and masks
  localparam int unsigned SpeedBit = 5;
  localparam logic [7:0] ModeMask = 8'h09;
  // values after reset, and the top of the count
  localparam logic [7:0] CtrlReset = 8'h00;
  localparam logic [7:0] ModeReset = 8'h00;
  localparam logic [15:0] CountReset = 16'h0000;
  localparam logic [15:0] CountTop = 16'hFFFF;
  // clocks per count step
  localparam int unsigned DivSlow = 12;
  localparam int unsigned DivFast = 4;
  localparam int unsigned DivBaud = 2;
  // AHB-Lite encodings
  localparam logic [1:0] TransNonseq = 2'h2;
  localparam logic [2:0] SizeWord = 3'h2;

  // control register fields, msb first
  typedef struct packed {
    logic ovf;
    logic ext;
    logic rxSel;
    logic txSel;
    logic extEn;
    logic run;
    logic cntSrc;
    logic capSel;
  } crt_ctrl_s;

  // mode register fields, msb first
  typedef struct packed {
    logic [3:0] rsvHi;
    logic capClr;
    logic [1:0] rsvLo;
    logic downEn;
  } crt_mode_s;
endpackage
`default_nettype wire

// [rtl/crt_tick_gen.sv]
// count step generator: prescaled core clock or external edges
// assumes extFall is already a one-cycle synced pulse
`default_nettype none
module crt_tick_gen #(
  parameter int unsigned DIV_SLOW = crt_pkg::DivSlow,
  parameter int unsigned DIV_FAST = crt_pkg::DivFast,
  parameter int unsigned DIV_BAUD = crt_pkg::DivBaud
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // mode
  input wire logic run,
  input wire logic baudMode,
  input wire logic extMode,
  input wire logic speedSel,
  input wire logic extFall,
  // step
  output logic tick
);
  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [3:0] last;
  logic divTick;

  // divisor select; baud mode ignores the source select
  assign last = baudMode ? 4'(DIV_BAUD - 1) : (speedSel ? 4'(DIV_FAST - 1) : 4'(DIV_SLOW - 1));
  assign divTick = pre_q >= last;
  assign tick = run & ((extMode & ~baudMode) ? extFall : divTick);
  assign pre_d = (!run || divTick) ? 4'h0 : pre_q + 4'h1;

  // prescaler restarts whenever counting stops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pre_q <= 4'h0;
    else
      pre_q <= pre_d;
  end
endmodule
`default_nettype wire

// [rtl/crt_timer.sv]
// 16-bit capture/reload timer with baud generator mode, AHB-Lite slave
// assumes one bus master, word accesses, pins synchronous to sys_clk
`default_nettype none
module crt_timer #(
  parameter int unsigned DIV_SLOW = crt_pkg::DivSlow,
  parameter int unsigned DIV_FAST = crt_pkg::DivFast
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // pins and neighbours
  input wire logic countPin,
  input wire logic trigPin,
  input wire logic timer1Ovf,
  // outputs
  output logic irqReq,
  output logic rxBaudTick,
  output logic txBaudTick
);
  // word address match on the index of a register
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] idx);
    hit = (addr[31:10] == 22'h0) && (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  crt_pkg::crt_ctrl_s ctrl_q;
  crt_pkg::crt_ctrl_s ctrl_d;
  crt_pkg::crt_mode_s mode_q;
  crt_pkg::crt_mode_s mode_d;
  logic [15:0] cap_q;
  logic [15:0] cap_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic speed_q;
  logic speed_d;
  logic [31:0] addr_q;
  logic wr_q;
  logic [31:0] rdata_d;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic irq_q;
  logic rxTick_q;
  logic txTick_q;
  logic trigLevel;
  logic trigFall;
  logic cntFall;
  logic tick;

  // pin conditioning
  crt_fall_detect u_trig (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(trigPin),
    .level(trigLevel),
    .fall(trigFall)
  );
  crt_fall_detect u_cnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(countPin),
    .level(),
    .fall(cntFall)
  );

  // bus address phase and data phase write strobes
  wire accept = hsel & hready & (htrans == crt_pkg::TransNonseq) & (hsize == crt_pkg::SizeWord);
  wire wrCtrl = wr_q & hit(addr_q, crt_pkg::IdxCtrl);
  wire wrMode = wr_q & hit(addr_q, crt_pkg::IdxMode);
  wire wrCapLo = wr_q & hit(addr_q, crt_pkg::IdxCapLo);
  wire wrCapHi = wr_q & hit(addr_q, crt_pkg::IdxCapHi);
  wire wrCntLo = wr_q & hit(addr_q, crt_pkg::IdxCntLo);
  wire wrCntHi = wr_q & hit(addr_q, crt_pkg::IdxCntHi);
  wire wrClk = wr_q & hit(addr_q, crt_pkg::IdxClkCtl);
  wire [7:0] wbyte = hwdata[7:0];

  // mode decode
  wire baudMode = ctrl_q.rxSel | ctrl_q.txSel;
  wire capMode = ctrl_q.capSel & ~baudMode;
  wire downMode = mode_q.downEn & ~capMode & ~baudMode & ~trigLevel;
  wire trigEvt = ctrl_q.extEn & ~baudMode & trigFall;
  wire capEvt = trigEvt & capMode;
  wire reloadEvt = trigEvt & ~capMode & ~mode_q.downEn;
  wire upWrap = tick & ~downMode & (cnt_q == crt_pkg::CountTop);
  wire downHit = tick & downMode & (cnt_q == cap_q);
  wire ovfEvt = upWrap | downHit;
  wire extOvf = ovfEvt & mode_q.downEn & ~capMode & ~baudMode;

  // count step source
  crt_tick_gen #(
    .DIV_SLOW(DIV_SLOW),
    .DIV_FAST(DIV_FAST),
    .DIV_BAUD(crt_pkg::DivBaud)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(ctrl_q.run),
    .baudMode(baudMode),
    .extMode(ctrl_q.cntSrc),
    .speedSel(speed_q),
    .extFall(cntFall),
    .tick(tick)
  );

  // count next value; software byte writes win over counting
  always_comb
  begin
    cnt_d = cnt_q;
    if (downHit)
      cnt_d = crt_pkg::CountTop;
    else if (upWrap)
      cnt_d = capMode ? crt_pkg::CountReset : cap_q;
    else if (tick)
      cnt_d = downMode ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    if (capEvt && mode_q.capClr)
      cnt_d = crt_pkg::CountReset;
    if (reloadEvt)
      cnt_d = cap_q;
    if (wrCntLo)
      cnt_d[7:0] = wbyte;
    if (wrCntHi)
      cnt_d[15:8] = wbyte;
  end

  // capture/reload value
  always_comb
  begin
    cap_d = cap_q;
    if (capEvt)
      cap_d = cnt_q;
    if (wrCapLo)
      cap_d[7:0] = wbyte;
    if (wrCapHi)
      cap_d[15:8] = wbyte;
  end

  // control and mode; hardware sets win over a clearing write
  always_comb
  begin
    ctrl_d = wrCtrl ? crt_pkg::crt_ctrl_s'(wbyte) : ctrl_q;
    ctrl_d.ovf = ctrl_d.ovf | (ovfEvt & ~baudMode);
    ctrl_d.ext = ctrl_d.ext | trigEvt | extOvf;
    mode_d = wrMode ? crt_pkg::crt_mode_s'(wbyte & crt_pkg::ModeMask) : mode_q;
    speed_d = wrClk ? wbyte[crt_pkg::SpeedBit] : speed_q;
  end

  // read data from next values so a read right after a write sees it
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hit(haddr, crt_pkg::IdxCtrl))
      rdata_d[7:0] = ctrl_d;
    if (hit(haddr, crt_pkg::IdxMode))
      rdata_d[7:0] = mode_d;
    if (hit(haddr, crt_pkg::IdxCapLo))
      rdata_d[7:0] = cap_d[7:0];
    if (hit(haddr, crt_pkg::IdxCapHi))
      rdata_d[7:0] = cap_d[15:8];
    if (hit(haddr, crt_pkg::IdxCntLo))
      rdata_d[7:0] = cnt_d[7:0];
    if (hit(haddr, crt_pkg::IdxCntHi))
      rdata_d[7:0] = cnt_d[15:8];
    if (hit(haddr, crt_pkg::IdxClkCtl))
      rdata_d[crt_pkg::SpeedBit] = speed_d;
  end

  // timer state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= crt_pkg::crt_ctrl_s'(crt_pkg::CtrlReset);
      mode_q <= crt_pkg::crt_mode_s'(crt_pkg::ModeReset);
      cap_q <= crt_pkg::CountReset;
      cnt_q <= crt_pkg::CountReset;
      speed_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      cap_q <= cap_d;
      cnt_q <= cnt_d;
      speed_q <= speed_d;
    end
  end

  // bus phase registers; zero wait states, always OKAY
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      addr_q <= haddr;
      wr_q <= accept & hwrite;
      hrdata_q <= (accept & ~hwrite) ? rdata_d : 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
  end

  // request and serial time bases
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
      rxTick_q <= 1'b0;
      txTick_q <= 1'b0;
    end
    else
    begin
      irq_q <= ctrl_d.ovf | ctrl_d.ext;
      rxTick_q <= ctrl_q.rxSel ? (ovfEvt & baudMode) : timer1Ovf;
      txTick_q <= ctrl_q.txSel ? (ovfEvt & baudMode) : timer1Ovf;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign irqReq = irq_q;
  assign rxBaudTick = rxTick_q;
  assign txBaudTick = txTick_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ovf_sets: assert property (ovfEvt && !baudMode |=> ctrl_q.ovf)
    else $error("overflow flag not set");
  a_ovf_baud_block: assert property (baudMode && !ctrl_q.ovf && !wrCtrl |=> !ctrl_q.ovf)
    else $error("overflow flag set in baud mode");
  a_ovf_sticky: assert property (ctrl_q.ovf && !wrCtrl |=> ctrl_q.ovf)
    else $error("overflow flag cleared by hardware");
  a_ext_edge: assert property (trigEvt |=> ctrl_q.ext ##1 irq_q)
    else $error("external flag or request missing");
  a_ext_sticky: assert property (ctrl_q.ext && !wrCtrl |=> ctrl_q.ext [*2] or wrCtrl)
    else $error("external flag cleared by hardware");
  a_stop_holds: assert property (!ctrl_q.run && !wrCntLo && !wrCntHi && !trigEvt |=> $stable(cnt_q))
    else $error("count moved while stopped");
  a_baud_rate: assert property (baudMode && tick |=> !tick)
    else $error("baud step faster than two clocks");
  a_capture_copy: assert property (capEvt && !wrCapLo && !wrCapHi |=> cap_q == $past(cnt_q))
    else $error("capture value wrong");
  a_capture_clear: assert property (capEvt && mode_q.capClr && !wrCntLo && !wrCntHi |=> cnt_q == 16'h0000)
    else $error("count not cleared after capture");
  a_down_wrap: assert property (downHit && !wrCntLo && !wrCntHi |=> cnt_q == 16'hFFFF)
    else $error("down wrap value wrong");
  a_tx_source: assert property (!ctrl_q.txSel |=> txBaudTick == $past(timer1Ovf))
    else $error("transmit time base not from timer 1");

  // serial time bases taken from timer 1, or from our own overflow when selected
  a_rx_source: assert property (!ctrl_q.rxSel |=> rxBaudTick == $past(timer1Ovf))
    else $error("receive time base not from timer 1");
  a_rx_own: assert property (ctrl_q.rxSel |=> rxBaudTick == $past(ovfEvt))
    else $error("receive time base not from own overflow");
  a_tx_own: assert property (ctrl_q.txSel |=> txBaudTick == $past(ovfEvt))
    else $error("transmit time base not from own overflow");

  // baud mode reloads after every overflow
  a_baud_reload: assert property (baudMode && upWrap && !wrCntLo && !wrCntHi |=> cnt_q == $past(cap_q))
    else $error("baud overflow did not reload");

  // trigger edge reload in reload mode
  a_reload_edge: assert property (reloadEvt && !wrCntLo && !wrCntHi |=> cnt_q == $past(cap_q))
    else $error("trigger reload value wrong");

  // disabled trigger leaves the external flag alone
  a_trig_ignored: assert property (trigFall && !ctrl_q.extEn && !ctrl_q.ext && !wrCtrl && !extOvf
    |=> !ctrl_q.ext)
    else $error("disabled trigger set external flag");

  // single steps in both directions
  a_count_up: assert property (tick && !downMode && cnt_q != 16'hFFFF && !reloadEvt && !capEvt
    && !wrCntLo && !wrCntHi |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("up step wrong");
  a_count_down: assert property (tick && downMode && cnt_q != cap_q && !wrCntLo && !wrCntHi
    |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("down step wrong");

  // counter mode steps only on a synced count pin edge
  a_count_src_ext: assert property (ctrl_q.cntSrc && !baudMode && !cntFall |-> !tick)
    else $error("counter mode step without pin edge");

  // request tracks both flags
  a_irq_flags: assert property (irqReq == (ctrl_q.ovf | ctrl_q.ext))
    else $error("request does not follow flags");

  // software byte write lands in the count
  a_cnt_byte_write: assert property (wrCntLo |=> cnt_q[7:0] == $past(wbyte))
    else $error("count low byte write lost");

  // software clear of the overflow flag works
  a_ovf_clear_sw: assert property (wrCtrl && !wbyte[7] && !(ovfEvt && !baudMode) |=> !ctrl_q.ovf)
    else $error("overflow flag not cleared by write");

  // trigger gated by its enable
  a_trig_gate: assert property (!ctrl_q.extEn |-> !capEvt && !reloadEvt)
    else $error("trigger acted while disabled");

  c_capture: cover property (capEvt);
  c_down_wrap: cover property (downHit);
  c_baud_ovf: cover property (baudMode && ovfEvt ##1 rxBaudTick);
  c_trig_reload: cover property (reloadEvt);
  c_pin_count: cover property (ctrl_q.cntSrc && tick);
endmodule
`default_nettype wire
